// ===== tb/lptg_props.sv
// Port checker for the lab pulse timing generator
`default_nettype none
module lptg_props #(
    parameter int FINE_W = 8
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [3:0] period_sel_i,
    input wire logic [3:0] delay_sel_i,
    input wire logic [3:0] width_sel_i,
    input wire logic [FINE_W-1:0] width_fine_adjust_i,
    input wire logic pulse_pair_select_i,
    input wire logic invert_select_i,
    input wire logic launch_gate_i,
    input wire logic manual_launch_button_i,
    input wire logic sync_o,
    input wire logic main_o,
    input wire logic ttl_o,
    input wire logic ttl_inv_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    // =========================================
    // Helper decode and counters
    // =========================================
    logic [7:0] hi_r;
    logic [7:0] lo_r;
    logic [8:0] wf_p1;
    logic [3:0] wexp;
    logic ext_w;
    logic xw;
    assign wf_p1 = 9'(width_fine_adjust_i) + 9'h001;
    assign wexp = (wf_p1[8:5] == 4'h0) ? 4'h1 : wf_p1[8:5];
    assign ext_w = period_sel_i == 4'h7 && width_sel_i == 4'h0 && delay_sel_i == 4'h0
        && !invert_select_i && !pulse_pair_select_i;
    assign xw = period_sel_i == 4'h7 && width_sel_i == 4'h7;
    // Run lengths, hi_r wrapping and lo_r saturating; gate low counts both pin and button
    always_ff @(posedge mclk_i)
    begin
        hi_r <= (rst_i || !main_o) ? 8'h00 : hi_r + 8'h01;
        lo_r <= (rst_i || launch_gate_i || manual_launch_button_i) ? 8'h00
            : lo_r + {7'h00, lo_r != 8'hff};
    end
    // =========================================
    // Assertions
    // =========================================
    chk_ttl_comp: assert property (ttl_inv_o == !ttl_o)
        else $error("inverted ttl not complement");
    chk_ttl_main: assert property (ttl_o == main_o)
        else $error("ttl differs from main");
    chk_ext_lag: assert property ($rose(main_o) && ext_w |->
        $past(launch_gate_i, 6) && !$past(launch_gate_i, 7))
        else $error("pulse without launch edge");
    chk_ext_width: assert property ($fell(main_o) && ext_w |-> hi_r == {4'h0, wexp})
        else $error("pulse width wrong");
    chk_sync_follow: assert property (period_sel_i == 4'h7 |->
        sync_o == $past(launch_gate_i))
        else $error("sync not following launch");
    chk_xw_follow: assert property (xw && !invert_select_i |->
        main_o == $past(launch_gate_i, 4))
        else $error("external width not followed");
    chk_xw_static: assert property (xw && lo_r > 8'h08 |-> main_o == invert_select_i)
        else $error("static level wrong");
    chk_gate_stop: assert property (period_sel_i < 4'h7 && lo_r > 8'h3f |->
        main_o == invert_select_i)
        else $error("pulses while gated off");
    cov_ext_pulse: cover property ($rose(main_o) && ext_w);
    cov_xw_pulse: cover property ($fell(main_o) && xw);
    cov_gate_off: cover property (period_sel_i < 4'h7 && lo_r == 8'h40);
endmodule // lptg_props
bind lptg_top lptg_props #(.FINE_W(FINE_W)) u_props (.mclk_i, .rst_i, .period_sel_i,
    .delay_sel_i, .width_sel_i, .width_fine_adjust_i, .pulse_pair_select_i,
    .invert_select_i, .launch_gate_i, .manual_launch_button_i, .sync_o, .main_o,
    .ttl_o, .ttl_inv_o);
`default_nettype wire

// ===== tb/lptg_src.sv
// Behavioural launch and gate source facing the generator
`default_nettype none
module lptg_src (
    input wire logic mclk_i,
    input wire logic fire_i,
    input wire logic use_button_i,
    input wire logic free_i,
    input wire logic [7:0] len_i,
    output logic gate_o,
    output logic button_o
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] left_r = 8'h00;
    // One request gives a high level for len cycles
    always_ff @(posedge mclk_i)
    begin
        if (fire_i)
            left_r <= len_i;
        else if (left_r != 8'h00)
            left_r <= left_r - 8'h01;
    end
    // Unterminated pin floats high, so a free pin reads as gate on
    assign gate_o = free_i || (left_r != 8'h00 && !use_button_i);
    assign button_o = left_r != 8'h00 && use_button_i;
endmodule // lptg_src
`default_nettype wire

// ===== tb/testbench.sv
// Self-checking bench for the lab pulse timing generator
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic [3:0] per_sel = 4'h7, dly_sel = 4'h0, wid_sel = 4'h0;
    logic [7:0] per_fine = 8'hff, dly_fine = 8'h00, wid_fine = 8'h00, len = 8'h04;
    logic pair = 1'b0, inv = 1'b0, fire = 1'b0, use_btn = 1'b0, free = 1'b0;
    logic gate, button, sync, main, ttl, ttl_inv;
    int n_mismatch = 0, compares = 0, seed = 97531;
    int i, d, w, rises, hi_cyc, syn_rises, lead, gap;
    // =========================================
    // Clock, design and source
    // =========================================
    initial forever #4 mclk_i = ~mclk_i;
    lptg_top dut (.mclk_i(mclk_i), .rst_i(rst_i), .period_sel_i(per_sel),
        .period_fine_adjust_i(per_fine), .delay_sel_i(dly_sel), .delay_fine_adjust_i(dly_fine),
        .width_sel_i(wid_sel), .width_fine_adjust_i(wid_fine), .pulse_pair_select_i(pair),
        .invert_select_i(inv), .launch_gate_i(gate), .manual_launch_button_i(button),
        .sync_o(sync), .main_o(main), .ttl_o(ttl), .ttl_inv_o(ttl_inv));
    lptg_src src (.mclk_i(mclk_i), .fire_i(fire), .use_button_i(use_btn), .free_i(free),
        .len_i(len), .gate_o(gate), .button_o(button));
    // =========================================
    // Helpers
    // =========================================
    function automatic int span(input logic [3:0] sel, input logic [7:0] f);
        int c;
        c = ((sel == 4'h0) ? 8 : 80) * (int'(f) + 1) / 256;
        return (c < 1) ? 1 : c;
    endfunction
    task automatic cmp_num(input string what, input int exp, input int got);
        compares++;
        if (got != exp)
        begin
            n_mismatch++;
            $display("FAIL %s expected %0d seen %0d", what, exp, got);
        end
    endtask
    task automatic cmp_bit(input string what, input logic exp, input logic got);
        compares++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("FAIL %s expected %b seen %b", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("compares %0d n_mismatch %0d", compares, n_mismatch);
        if (n_mismatch == 0 && compares > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // Settings change with reset held, so no old sequence leaks across
    task automatic restart();
        rst_i <= 1'b1;
        repeat (6) @(posedge mclk_i);
        rst_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
    endtask
    task automatic launch();
        fire <= 1'b1;
        @(posedge mclk_i);
        fire <= 1'b0;
    endtask
    // Active level is main xor invert; ends on a rising edge
    task automatic watch(input int n);
        logic pm;
        logic ps;
        rises = 0;
        hi_cyc = 0;
        syn_rises = 0;
        pm = main ^ inv;
        ps = sync;
        for (int k = 0; k < n; k++)
        begin
            @(negedge mclk_i);
            if ((main ^ inv) && !pm)
            begin
                rises++;
                if (rises == 1)
                    lead = k;
                if (rises == 2)
                    gap = k - lead;
            end
            hi_cyc += int'(main ^ inv);
            syn_rises += int'(sync && !ps);
            pm = main ^ inv;
            ps = sync;
        end
        @(posedge mclk_i);
    endtask
    // =========================================
    // Scenarios
    // =========================================
    initial
    begin
        // Launch shots: external pin and button, single and pair, both polarities
        @(posedge mclk_i);
        for (i = 0; i < 12; i++)
        begin
            per_sel <= (i % 3 == 2) ? 4'h8 : 4'h7;
            use_btn <= (i % 3 == 2);
            pair <= i[0];
            inv <= i[1];
            dly_sel <= (i == 0) ? 4'h0 : 4'($random(seed) & 1);
            wid_sel <= (i == 0) ? 4'h0 : 4'($random(seed) & 1);
            dly_fine <= 8'($random(seed));
            wid_fine <= 8'($random(seed));
            per_fine <= 8'($random(seed));
            restart();
            launch();
            watch(400);
            d = (dly_sel == 4'h0) ? 1 : span(4'h0, dly_fine);
            w = span(wid_sel, wid_fine);
            cmp_num("pulse count", pair ? 2 : 1, rises);
            if (!pair)
                cmp_num("lead time", 5 + d, lead);
            cmp_num("active cycles", (pair ? 2 : 1) * w, hi_cyc);
            if (pair)
                cmp_num("pair gap", (d > w) ? d : w + 1, gap);
            cmp_bit("idle level", inv, main);
        end
        // Continuous: short delay and width keep the sequence inside the period
        per_sel <= 4'h0;
        free <= 1'b1;
        use_btn <= 1'b0;
        pair <= 1'b0;
        inv <= 1'b0;
        dly_sel <= 4'h0;
        for (i = 0; i < 3; i++)
        begin
            per_fine <= (i == 1) ? 8'h7f : 8'hff;
            wid_sel <= (i == 2) ? 4'h7 : 4'h0;
            wid_fine <= (i == 2) ? 8'($random(seed)) : 8'h1f;
            restart();
            watch(160);
            cmp_num("pulse rate", (i == 1) ? 20 : 10, rises);
            cmp_num("sync rate", (i == 1) ? 20 : 10, syn_rises);
            cmp_num("high cycles", (i == 2) ? 80 : ((i == 1) ? 20 : 10), hi_cyc);
        end
        // Gate pin low stops output; button then gates it on
        free <= 1'b0;
        watch(80);
        watch(100);
        cmp_num("gated off", 0, rises);
        use_btn <= 1'b1;
        len <= 8'h68;
        launch();
        watch(200);
        cmp_num("button gate", 7, rises);
        // External width with static level in both polarities
        per_sel <= 4'h7;
        wid_sel <= 4'h7;
        use_btn <= 1'b0;
        for (i = 0; i < 2; i++)
        begin
            inv <= i[0];
            len <= 8'(3 + ($random(seed) & 31));
            restart();
            repeat (12) @(posedge mclk_i);
            cmp_bit("static level", i[0], main);
            launch();
            watch(80);
            cmp_num("external width", len, hi_cyc);
        end
        tally_and_finish();
    end
    // Whole run needs under 12000 cycles
    initial
    begin
        repeat (40000) @(posedge mclk_i);
        n_mismatch++;
        tally_and_finish();
    end
endmodule // testbench
`default_nettype wire

// ===== verilog/lptg_pkg.sv
// Package of constants for the lab pulse timing generator
`default_nettype none
package lptg_pkg;
    // =========================================
    // Selector encodings
    // =========================================
    localparam logic [3:0] PER_RANGES = 4'h7;
    localparam logic [3:0] PER_EXT_LAUNCH = 4'h7;
    localparam logic [3:0] PER_MAN_LAUNCH = 4'h8;
    localparam logic [3:0] DLY_OFF = 4'h0;
    localparam logic [3:0] WID_SQUARE = 4'h7;
    // =========================================
    // Timing
    // =========================================
    localparam int CLK_MHZ = 125;
    localparam int FIXED_DELAY_NS = 20;
    // Least time: round up
    localparam int FIXED_DELAY_CYC = (FIXED_DELAY_NS * CLK_MHZ + 999) / 1000;
    localparam int BASE_CYC = 8;
    localparam int FINE_W = 8;
    localparam int CNT_W = 32;
    localparam logic [CNT_W-1:0] DEF_PER_HALF = 32'h0000_00fa;
    typedef enum logic [2:0] {
        LPTG_IDLE = 3'b000,
        LPTG_FIX = 3'b001,
        LPTG_DLY = 3'b010,
        LPTG_W1 = 3'b011,
        LPTG_GAP = 3'b100,
        LPTG_W2 = 3'b101
    } lptg_state_t;
endpackage
`default_nettype wire

// ===== verilog/lptg_scale.sv
// Range and fine adjust to cycle count scaler
`default_nettype none
module lptg_scale #(
    parameter int CNT_W = 32,
    parameter int FINE_W = 8
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [3:0] range_i,
    input wire logic [FINE_W-1:0] fine_i,
    output logic [CNT_W-1:0] cycles_o
);
    // =========================================
    // Registered scaling
    // =========================================
    // Decade range times (fine+1), shifted right by FINE_W; larger fine gives longer time
    logic [CNT_W-1:0] decade;
    logic [CNT_W-1:0] prod;
    always_comb
    begin
        decade = CNT_W'(lptg_pkg::BASE_CYC);
        for (int i = 0; i < 7; i++)
        begin
            if (i < int'(range_i))
            begin
                decade = CNT_W'(decade * 10);
            end
        end
        prod = CNT_W'(decade * (CNT_W'(fine_i) + CNT_W'(1)) >> FINE_W);
        if (prod == '0)
        begin
            prod = CNT_W'(1);
        end
    end
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
            cycles_o <= CNT_W'(1);
        else
            cycles_o <= prod;
    end
endmodule // lptg_scale
`default_nettype wire

// ===== verilog/lptg_top.sv
// Timing and mode core of the lab pulse timing generator
// Notes on behaviour
// - External launch: idle until rising edge, one shot
// - Manual launch: button press gives one shot
// - Seven period ranges; fine clockwise lengthens period
// - Seven delay ranges; off gives minimum delay
// - Delay fine clockwise lengthens delay
// - Square setting gives half duty, ignores fine
// - Pair mode: second pulse after the larger of delay and width plus one
// - Invert swaps levels except sync
// - Inverted TTL is exact complement of TTL
// - Sync square, follows launch in launch modes
// - Launch on rising edge; low input stops pulses
// - Gated: pulses while gate high
// - Gated low: button gates pulses while pressed
// - Launch plus square: width follows launch signal
// - Fixed delay between sync and pulse
// - Launch, square, no input: static output
// - Default settings give half duty outputs
`default_nettype none
module lptg_top #(
    parameter int CNT_W = lptg_pkg::CNT_W,
    parameter int FINE_W = lptg_pkg::FINE_W
) (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic [3:0] period_sel_i,
    input wire logic [FINE_W-1:0] period_fine_adjust_i,
    input wire logic [3:0] delay_sel_i,
    input wire logic [FINE_W-1:0] delay_fine_adjust_i,
    input wire logic [3:0] width_sel_i,
    input wire logic [FINE_W-1:0] width_fine_adjust_i,
    input wire logic pulse_pair_select_i,
    input wire logic invert_select_i,
    input wire logic launch_gate_i,
    input wire logic manual_launch_button_i,
    output logic sync_o,
    output logic main_o,
    output logic ttl_o,
    output logic ttl_inv_o
);
    // =========================================
    // Mode decode
    // =========================================
    wire logic ext_launch = (period_sel_i == lptg_pkg::PER_EXT_LAUNCH);
    wire logic man_launch = (period_sel_i == lptg_pkg::PER_MAN_LAUNCH);
    wire logic launch_mode = ext_launch | man_launch;
    wire logic square_w = (width_sel_i == lptg_pkg::WID_SQUARE);
    wire logic ext_width = launch_mode & square_w;
    wire logic dly_off = (delay_sel_i == lptg_pkg::DLY_OFF);
    // Launch source: pin in external mode, button in manual mode
    wire logic launch_src = man_launch ? manual_launch_button_i : launch_gate_i;
    // Gate is high from pin, or button when pin held low
    wire logic gate_on = launch_gate_i | manual_launch_button_i;
    // =========================================
    // Range scaling
    // =========================================
    logic [CNT_W-1:0] per_half;
    logic [CNT_W-1:0] dly_cyc_raw;
    logic [CNT_W-1:0] wid_cyc;
    // Period ranges are the first seven selector codes
    wire logic [3:0] per_rng = launch_mode ? 4'h0 : period_sel_i;
    wire logic [3:0] dly_rng = dly_off ? 4'h0 : delay_sel_i - 4'h1;
    lptg_scale #(.CNT_W(CNT_W), .FINE_W(FINE_W)) u_per_scale (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .range_i(per_rng),
        .fine_i(period_fine_adjust_i),
        .cycles_o(per_half)
    );
    // Delay uses the same scaler, a second instance
    lptg_scale #(.CNT_W(CNT_W), .FINE_W(FINE_W)) u_dly_scale (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .range_i(dly_rng),
        .fine_i(delay_fine_adjust_i),
        .cycles_o(dly_cyc_raw)
    );
    lptg_scale #(.CNT_W(CNT_W), .FINE_W(FINE_W)) u_wid_scale (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .range_i(width_sel_i),
        .fine_i(width_fine_adjust_i),
        .cycles_o(wid_cyc)
    );
    // Off position: minimum of one cycle
    wire logic [CNT_W-1:0] dly_cyc = dly_off ? CNT_W'(1) : dly_cyc_raw;
    // =========================================
    // Input edge detection
    // =========================================
    logic launch_d_r;
    logic gate_d_r;
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            launch_d_r <= 1'b0;
            gate_d_r <= 1'b0;
        end
        else
        begin
            launch_d_r <= launch_src;
            gate_d_r <= gate_on;
        end
    end
    wire logic launch_rise = launch_src & ~launch_d_r;
    wire logic gate_rise = gate_on & ~gate_d_r;
    // =========================================
    // Period oscillator
    // =========================================
    // Stopped while gate low; restarts in step with gate rising edge
    logic [CNT_W-1:0] osc_cnt_r;
    logic [CNT_W-1:0] osc_cnt_nxt;
    logic osc_r;
    logic osc_nxt;
    wire logic osc_wrap = (osc_cnt_r >= per_half - CNT_W'(1));
    wire logic osc_run = ~launch_mode & gate_on;
    always_comb
    begin
        osc_cnt_nxt = osc_cnt_r;
        osc_nxt = osc_r;
        if (!osc_run)
        begin
            osc_cnt_nxt = '0;
            osc_nxt = 1'b0;
        end
        else if (gate_rise)
        begin
            osc_cnt_nxt = '0;
            osc_nxt = 1'b1;
        end
        else if (osc_wrap)
        begin
            // Fine clockwise raises per_half, so period grows
            osc_cnt_nxt = '0;
            osc_nxt = ~osc_r;
        end
        else
        begin
            osc_cnt_nxt = osc_cnt_r + CNT_W'(1);
        end
    end
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            osc_cnt_r <= '0;
            osc_r <= 1'b0;
        end
        else
        begin
            osc_cnt_r <= osc_cnt_nxt;
            osc_r <= osc_nxt;
        end
    end
    wire logic osc_rise = osc_nxt & ~osc_r;
    // Cycle start pulse for the one-shot chain
    wire logic cyc_start = launch_mode ? launch_rise : (osc_rise & osc_run);
    // =========================================
    // Delay and width one-shot chain
    // =========================================
    // Fixed delay, then delay, then width; pair skips the delay and inserts a gap
    lptg_pkg::lptg_state_t st_r;
    lptg_pkg::lptg_state_t st_nxt;
    logic [CNT_W-1:0] tmr_r;
    logic [CNT_W-1:0] tmr_nxt;
    logic [CNT_W-1:0] gap_r;
    logic [CNT_W-1:0] gap_nxt;
    logic pulse_r;
    logic pulse_nxt;
    wire logic tmr_done = (tmr_r <= CNT_W'(1));
    // Gap after first pulse so second follows first by the larger of delay and width plus one
    wire logic [CNT_W-1:0] gap_len = (dly_cyc > wid_cyc) ? dly_cyc - wid_cyc : CNT_W'(1);
    always_comb
    begin
        st_nxt = st_r;
        tmr_nxt = tmr_done ? tmr_r : tmr_r - CNT_W'(1);
        gap_nxt = gap_r;
        pulse_nxt = 1'b0;
        case (st_r)
            lptg_pkg::LPTG_IDLE:
            begin
                if (cyc_start)
                begin
                    st_nxt = lptg_pkg::LPTG_FIX;
                    tmr_nxt = CNT_W'(lptg_pkg::FIXED_DELAY_CYC);
                    gap_nxt = gap_len;
                end
            end
            lptg_pkg::LPTG_FIX:
            begin
                if (tmr_done)
                begin
                    // Pair mode: delay sets spacing, not lead-in
                    st_nxt = pulse_pair_select_i ? lptg_pkg::LPTG_W1 : lptg_pkg::LPTG_DLY;
                    tmr_nxt = pulse_pair_select_i ? wid_cyc : dly_cyc;
                    pulse_nxt = pulse_pair_select_i;
                end
            end
            lptg_pkg::LPTG_DLY:
            begin
                if (tmr_done)
                begin
                    st_nxt = lptg_pkg::LPTG_W1;
                    tmr_nxt = wid_cyc;
                    pulse_nxt = 1'b1;
                end
            end
            lptg_pkg::LPTG_W1:
            begin
                // Width runs to the end even if gate drops
                pulse_nxt = ~tmr_done;
                if (tmr_done)
                begin
                    st_nxt = pulse_pair_select_i ? lptg_pkg::LPTG_GAP : lptg_pkg::LPTG_IDLE;
                    tmr_nxt = gap_r;
                end
            end
            lptg_pkg::LPTG_GAP:
            begin
                if (tmr_done)
                begin
                    st_nxt = lptg_pkg::LPTG_W2;
                    tmr_nxt = wid_cyc;
                    pulse_nxt = 1'b1;
                end
            end
            lptg_pkg::LPTG_W2:
            begin
                pulse_nxt = ~tmr_done;
                if (tmr_done)
                begin
                    st_nxt = lptg_pkg::LPTG_IDLE;
                end
            end
            default:
            begin
                st_nxt = lptg_pkg::LPTG_IDLE;
            end
        endcase
    end
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            st_r <= lptg_pkg::LPTG_IDLE;
            tmr_r <= '0;
            gap_r <= '0;
            pulse_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            tmr_r <= tmr_nxt;
            gap_r <= gap_nxt;
            pulse_r <= pulse_nxt;
        end
    end
    // =========================================
    // Fixed delay line for square and external width paths
    // =========================================
    // Keeps the fixed lag on every path so edges line up
    localparam int FD = lptg_pkg::FIXED_DELAY_CYC;
    logic [FD-1:0] sq_dl_r;
    logic [FD-1:0] ew_dl_r;
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            sq_dl_r <= '0;
            ew_dl_r <= '0;
        end
        else
        begin
            sq_dl_r <= {sq_dl_r[FD-2:0], osc_r};
            ew_dl_r <= {ew_dl_r[FD-2:0], launch_src};
        end
    end
    // =========================================
    // Output selection
    // =========================================
    // Square setting bypasses one-shots: half duty, fine ignored
    wire logic active_sq = ~launch_mode & square_w & sq_dl_r[FD-1];
    // External width copies launch level; idle input keeps it static
    wire logic active_ew = ext_width & ew_dl_r[FD-1];
    wire logic active_os = ~square_w & pulse_r;
    wire logic active = active_sq | active_ew | active_os;
    wire logic level = active ^ invert_select_i;
    // Sync follows launch input in launch modes, else oscillator
    wire logic sync_src = launch_mode ? launch_src : osc_r;
    always_ff @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            sync_o <= 1'b0;
            main_o <= 1'b0;
            ttl_o <= 1'b0;
            ttl_inv_o <= 1'b1;
        end
        else
        begin
            sync_o <= sync_src; // (sync not inverted)
            main_o <= level;
            ttl_o <= level;
            ttl_inv_o <= ~level;
        end
    end
endmodule // lptg_top
`default_nettype wire
